// [hw/rly_ctrl.sv]
// Relay output controller: ratio, flow proportional, counter timer, dual switch
// What this block does
// - Ratio mode turns relay on when makeup volume reaches accumulator volume.
// - While on, bleed volume is counted; relay turns off at bleed volume.
// - Second makeup or bleed meter may be none; then only first counts.
// - Counts of both selected meters of a kind are added together.
// - Liter/gallon percent is target times flow over product times 166.67.
// - Cubic meter flow uses divisor constant 0.16667 instead.
// - Automatic flow output continuously on beyond time limit is switched off.
// - Maximum pulse rate is held within 10 to 2400; 100 percent equals it.
// - In hand position flow output uses the hand output percent.
// - Counter timer counts closures and starts feed at accumulated setpoint.
// - Feed lasts exactly the feed duration; remaining time is reported.
// - Dual switch starts activating when on-source enters its state.
// - Dual switch starts deactivating when off-source enters its state.
// - Relay turns on after on delay; zero delay turns on at once.
// - Relay turns off after off delay; zero delay turns off at once.
// - Trigger relay changes count only when that relay is automatic.
// - Cycle on-time and total on-time kept; total cleared only by reset write.
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module rly_ctrl
   import rly_pkg::*;
#(
   parameter int NDI     = 8,
   parameter int NOR     = 4,
   parameter int SEC_CNT = SEC_CYC
) (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic [7:0]        reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [31:0]       reg_rdata,
   input  wire logic [NDI-1:0]    din_pin,
   input  wire logic [NOR-1:0]    oth_relay,
   input  wire logic [NOR-1:0]    oth_auto,
   input  wire logic [15:0]       flow_rate,
   output logic                   relay_out,
   output logic                   irq
);

   if (NDI + NOR > 15 || NDI < 1 || NOR < 1 || SEC_CNT < 2) begin : g_chk
      $error("rly_ctrl: unsupported parameter values");
   end

   function automatic logic [1:0] hit(input logic [3:0] s, input logic [15:0] v);
      hit = (s == SEL_NONE) ? 2'h0 : {1'b0, v[s]};
   endfunction

   function automatic logic [31:0] hms_sec(input rly_hms_t t);
      hms_sec = 32'(t.hh) * HR_SEC + 32'(t.mm) * MIN_SEC + 32'(t.ss);
   endfunction

   // ****************************************
   // Registers
   // ****************************************
   logic [31:0]    ctrl_q;
   rly_sel_t       sel_q;
   logic [31:0]    accv_q;
   logic [31:0]    bldv_q;
   logic [31:0]    fpa_q;
   logic [31:0]    fpb_q;
   logic [31:0]    rate_q;
   logic [31:0]    ct_q;
   rly_hms_t       ond_q;
   rly_hms_t       offd_q;
   logic [NEV-1:0] msk_q;
   logic [NEV-1:0] ist_q;
   logic [NEV-1:0] ist_d;
   logic [NEV-1:0] ev;
   logic [31:0]    rdata_d;
   logic           tot_clr;

   wire wr_cfg = reg_wr;
   wire [1:0] mode = ctrl_q[1:0];
   wire [1:0] hand_off_auto_selector = ctrl_q[5:4];
   wire auto_m = (hand_off_auto_selector == H_AUTO);
   wire hand_m = (hand_off_auto_selector == H_HAND);
   assign tot_clr = reg_wr && reg_addr == A_TOTON;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_q <= REG_RST;
         sel_q  <= rly_sel_t'(REG_RST);
         accv_q <= REG_RST;
         bldv_q <= REG_RST;
         fpa_q  <= REG_RST;
         fpb_q  <= REG_RST;
         rate_q <= REG_RST;
         ct_q   <= REG_RST;
         ond_q  <= rly_hms_t'(REG_RST);
         offd_q <= rly_hms_t'(REG_RST);
         msk_q  <= NEV'(REG_RST);
      end else if (wr_cfg) begin
         case (reg_addr)
            A_CTRL:  ctrl_q <= reg_wdata;
            A_SEL:   sel_q <= rly_sel_t'(reg_wdata);
            A_ACCV:  accv_q <= reg_wdata;
            A_BLDV:  bldv_q <= reg_wdata;
            A_FPA:   fpa_q <= reg_wdata;
            A_FPB:   fpb_q <= reg_wdata;
            A_RATE:  rate_q <= reg_wdata;
            A_CT:    ct_q <= reg_wdata;
            A_OND:   ond_q <= rly_hms_t'(reg_wdata);
            A_OFFD:  offd_q <= rly_hms_t'(reg_wdata);
            A_IMSK:  msk_q <= reg_wdata[NEV-1:0];
            default: ;
         endcase
      end
   end

   // ****************************************
   // Input conditioning
   // ****************************************
   // Pins pass three flops; a level counts once the last two agree
   logic [NDI-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
   logic [NOR-1:0] oth_p_q;
   assign filt_d = (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
   wire [15:0] lvl = 16'({oth_relay, filt_d});
   // Forced hand/off changes of a trigger relay are masked out
   wire [15:0] chg = 16'({(oth_relay ^ oth_p_q) & oth_auto, filt_d ^ filt_q});
   wire [15:0] rise = chg & lvl;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         s1_q    <= '0;
         s2_q    <= '0;
         s3_q    <= '0;
         filt_q  <= '0;
         oth_p_q <= '0;
      end else begin
         s1_q    <= din_pin;
         s2_q    <= s1_q;
         s3_q    <= s2_q;
         filt_q  <= filt_d;
         oth_p_q <= oth_relay;
      end
   end

   // ****************************************
   // Seconds prescaler
   // ****************************************
   // Restarted when a timed feed or delay starts so its first second is whole
   logic [31:0] pre_q;
   logic        tmr_go;
   wire tick = (pre_q == 32'(SEC_CNT - 1));
   always_ff @(posedge clk) begin
      if (sys_rst || tmr_go || tick) pre_q <= '0;
      else pre_q <= pre_q + 32'h1;
   end

   // ****************************************
   // Flow meter ratio
   // ****************************************
   logic        rat_on_q;
   logic [31:0] mk_acc_q, bl_acc_q;
   wire [1:0]  mk_n = hit(sel_q.mk1, rise) + hit(sel_q.mk2, rise);
   wire [1:0]  bl_n = hit(sel_q.bl1, rise) + hit(sel_q.bl2, rise);
   wire [31:0] mk_sum = mk_acc_q + 32'(mk_n);
   wire [31:0] bl_sum = bl_acc_q + 32'(bl_n);
   wire rat_go = !rat_on_q && mk_sum >= accv_q;
   wire rat_end = rat_on_q && bl_sum >= bldv_q;

   always_ff @(posedge clk) begin
      if (sys_rst || mode != M_RATIO) begin
         rat_on_q <= 1'b0;
         mk_acc_q <= '0;
         bl_acc_q <= '0;
      end else if (!rat_on_q) begin
         rat_on_q <= rat_go;
         mk_acc_q <= rat_go ? 32'h0 : mk_sum;
         bl_acc_q <= '0;
      end else begin
         rat_on_q <= !rat_end;
         bl_acc_q <= bl_sum;
      end
   end

   // ****************************************
   // Flow proportional: percent by long division
   // ****************************************
   logic [63:0] dv_rem_q, dv_quo_q, dv_den_q;
   logic [5:0]  dv_cnt_q;
   logic        dv_busy_q;
   logic [6:0]  pct_q;
   wire [63:0] num_w = 64'(fpa_q[15:0]) * 64'(flow_rate)
                     * (ctrl_q[CTRL_M3] ? K_M3_MUL : K_LG_MUL);
   wire [63:0] den_w = 64'(fpb_q[7:0]) * 64'(fpa_q[31:16]) * 64'(fpb_q[15:8])
                     * 64'(fpb_q[23:16]) * K_DIV;
   wire [63:0] dv_sh = {dv_rem_q[62:0], dv_quo_q[63]};
   wire        dv_ge = dv_sh >= dv_den_q;
   wire [63:0] quo_nx = {dv_quo_q[62:0], dv_ge};
   wire [6:0]  pct_res = (dv_den_q == 64'h0) ? 7'h0
                       : (quo_nx > 64'(PCT_FULL)) ? PCT_FULL : quo_nx[6:0];

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dv_busy_q <= 1'b0;
         dv_cnt_q  <= '0;
         dv_rem_q  <= '0;
         dv_quo_q  <= '0;
         dv_den_q  <= '0;
         pct_q     <= '0;
      end else if (!dv_busy_q) begin
         dv_busy_q <= 1'b1;
         dv_cnt_q  <= '0;
         dv_rem_q  <= '0;
         dv_quo_q  <= num_w;
         dv_den_q  <= den_w;
      end else begin
         dv_rem_q <= dv_ge ? dv_sh - dv_den_q : dv_sh;
         dv_quo_q <= quo_nx;
         dv_cnt_q <= dv_cnt_q + 6'h1;
         if (dv_cnt_q == 6'h3f) begin
            dv_busy_q <= 1'b0;
            pct_q     <= pct_res;
         end
      end
   end

   // Output time limit on continuous automatic output
   logic [31:0] run_q;
   logic        lim_q;
   wire fp_auto = mode == M_FLOWP && auto_m;
   wire lim_d = fp_auto && pct_q != 7'h0
              && (lim_q || (rate_q[31:16] != 16'h0 && run_q >= 32'(rate_q[31:16])));
   wire [6:0] pct_eff = (mode != M_FLOWP) ? 7'h0
                      : hand_m ? fpb_q[30:24]
                      : (fp_auto && !lim_q) ? pct_q : 7'h0;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         run_q <= '0;
         lim_q <= 1'b0;
      end else begin
         run_q <= !(fp_auto && pct_q != 7'h0) ? 32'h0 : run_q + 32'(tick);
         lim_q <= lim_d;
      end
   end

   // Pulse phase accumulator: full scale gives the maximum rate per minute
   localparam logic [47:0] PTHR = 48'(PCT_FULL) * SEC_MIN * 48'(SEC_CNT);
   logic [47:0] pacc_q;
   wire [11:0] rate_eff = (rate_q[11:0] < RATE_MIN) ? RATE_MIN
                        : (rate_q[11:0] > RATE_MAX) ? RATE_MAX : rate_q[11:0];
   wire [47:0] pacc_s = pacc_q + 48'(pct_eff) * 48'(rate_eff);
   wire        pfire = pacc_s >= PTHR;
   always_ff @(posedge clk) begin
      if (sys_rst || pct_eff == 7'h0) pacc_q <= '0;
      else pacc_q <= pfire ? pacc_s - PTHR : pacc_s;
   end

   // ****************************************
   // Counter timer
   // ****************************************
   logic [31:0] ct_cnt_q, feed_q;
   wire [1:0] ct_hit = hit(sel_q.ct_src, rise);
   wire ct_trig = mode == M_CNTT && feed_q == 32'h0 && ct_q[15:0] != 16'h0
                && ct_cnt_q >= 32'(ct_q[15:0]);
   always_ff @(posedge clk) begin
      if (sys_rst || mode != M_CNTT) begin
         ct_cnt_q <= '0;
         feed_q   <= '0;
      end else begin
         ct_cnt_q <= (ct_trig ? 32'h0 : ct_cnt_q) + 32'(ct_hit);
         if (ct_trig) feed_q <= 32'(ct_q[31:16]);
         else if (tick && feed_q != 32'h0) feed_q <= feed_q - 32'h1;
      end
   end

   // ****************************************
   // Dual switch
   // ****************************************
   rly_ds_t     ds_q, ds_d;
   logic [31:0] dly_q, dly_d;
   logic        ds_go;
   wire on_ev = chg[sel_q.on_src] && lvl[sel_q.on_src] == sel_q.on_st;
   wire off_ev = chg[sel_q.off_src] && lvl[sel_q.off_src] == sel_q.off_st;
   wire [31:0] ond_s = hms_sec(ond_q);
   wire [31:0] offd_s = hms_sec(offd_q);
   wire dly_end = tick && dly_q <= 32'h1;

   always_comb begin
      ds_d  = ds_q;
      dly_d = tick ? dly_q - 32'h1 : dly_q;
      ds_go = 1'b0;
      case (ds_q)
         DS_OFF: begin
            dly_d = '0;
            if (on_ev) begin
               ds_d  = (ond_s == 32'h0) ? DS_ON : DS_ONDLY;
               dly_d = ond_s;
               ds_go = 1'b1;
            end
         end
         DS_ONDLY: begin
            if (off_ev) ds_d = DS_OFF;
            else if (dly_end) ds_d = DS_ON;
         end
         DS_ON: begin
            dly_d = '0;
            if (off_ev) begin
               ds_d  = (offd_s == 32'h0) ? DS_OFF : DS_OFFDLY;
               dly_d = offd_s;
               ds_go = 1'b1;
            end
         end
         DS_OFFDLY: begin
            if (on_ev) ds_d = DS_ON;
            else if (dly_end) ds_d = DS_OFF;
         end
         default: ds_d = DS_OFF;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst || mode != M_DUAL) begin
         ds_q  <= DS_OFF;
         dly_q <= '0;
      end else begin
         ds_q  <= ds_d;
         dly_q <= dly_d;
      end
   end
   assign tmr_go = ct_trig || (mode == M_DUAL && ds_go);

   // ****************************************
   // Relay output, on-time and events
   // ****************************************
   logic        relay_d, act_q;
   logic [31:0] cyon_q, toton_q;
   wire ds_rly = ds_q == DS_ON || ds_q == DS_OFFDLY;
   wire act = (mode == M_FLOWP) ? pct_eff != 7'h0 : relay_out;

   always_comb begin
      case (mode)
         M_RATIO: relay_d = rat_on_q;
         M_FLOWP: relay_d = pfire;
         M_CNTT:  relay_d = feed_q != 32'h0;
         default: relay_d = ds_rly;
      endcase
      if (mode != M_FLOWP && !auto_m) relay_d = hand_m;
   end

   assign ev[EV_ON]  = relay_d && !relay_out;
   assign ev[EV_OFF] = !relay_d && relay_out;
   assign ev[EV_LIM] = lim_d && !lim_q;
   assign ev[EV_CT]  = ct_trig;
   wire [NEV-1:0] ist_clr = (reg_wr && reg_addr == A_IST) ? reg_wdata[NEV-1:0] : '0;
   // A new event wins over a write-one clear in the same cycle
   assign ist_d = (ist_q & ~ist_clr) | ev;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         relay_out <= 1'b0;
         act_q     <= 1'b0;
         cyon_q    <= '0;
         toton_q   <= '0;
         ist_q     <= '0;
         irq       <= 1'b0;
      end else begin
         relay_out <= relay_d;
         act_q     <= act;
         cyon_q    <= (act && !act_q) ? 32'h0 : cyon_q + 32'(act && tick);
         toton_q   <= tot_clr ? 32'h0 : toton_q + 32'(act && tick);
         ist_q     <= ist_d;
         irq       <= |(ist_d & msk_q);
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   wire [31:0] stat_w = {21'h0, ds_q, lim_q, relay_out, pct_eff};
   wire [31:0] rem_w = (mode == M_CNTT) ? feed_q
                     : (bl_acc_q >= bldv_q) ? 32'h0 : bldv_q - bl_acc_q;
   always_comb begin
      case (reg_addr)
         A_CTRL:  rdata_d = ctrl_q;
         A_SEL:   rdata_d = sel_q;
         A_ACCV:  rdata_d = accv_q;
         A_BLDV:  rdata_d = bldv_q;
         A_FPA:   rdata_d = fpa_q;
         A_FPB:   rdata_d = fpb_q;
         A_RATE:  rdata_d = rate_q;
         A_CT:    rdata_d = ct_q;
         A_OND:   rdata_d = ond_q;
         A_OFFD:  rdata_d = offd_q;
         A_STAT:  rdata_d = stat_w;
         A_IST:   rdata_d = 32'(ist_q);
         A_IMSK:  rdata_d = 32'(msk_q);
         A_MKACC: rdata_d = (mode == M_CNTT) ? ct_cnt_q : mk_acc_q;
         A_REM:   rdata_d = rem_w;
         A_CYON:  rdata_d = cyon_q;
         A_TOTON: rdata_d = toton_q;
         default: rdata_d = '0;
      endcase
   end
   always_ff @(posedge clk) begin
      if (sys_rst || !reg_rd) reg_rdata <= '0;
      else reg_rdata <= rdata_d;
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_ct_fire;
      ct_trig && auto_m;
   endsequence

   ratio_on_a: assert property (mode == M_RATIO && auto_m && rat_go
      ##1 mode == M_RATIO && auto_m |=> relay_out)
      else $error("ratio relay did not turn on");
   ratio_off_a: assert property (mode == M_RATIO && auto_m && rat_end
      ##1 mode == M_RATIO && auto_m |=> !relay_out)
      else $error("ratio relay did not turn off");
   none_meter_a: assert property (sel_q.mk2 == SEL_NONE
      |-> mk_n == hit(sel_q.mk1, rise))
      else $error("second makeup meter counted while none");
   both_meter_a: assert property (mode == M_RATIO && !rat_on_q && !rat_go
      && mk_n == 2'h2 && $stable(mode) |=> mk_acc_q == $past(mk_acc_q) + 32'h2)
      else $error("two makeup pulses not both counted");
   rate_clamp_a: assert property (rate_eff >= RATE_MIN && rate_eff <= RATE_MAX)
      else $error("pulse rate out of range");
   hand_pct_a: assert property (mode == M_FLOWP && hand_m |-> pct_eff == fpb_q[30:24])
      else $error("hand percent not used");
   lim_off_a: assert property (lim_q && !hand_m |-> pct_eff == 7'h0)
      else $error("limited output still active");
   ct_clear_a: assert property (s_ct_fire |=> ct_cnt_q <= 32'h1
      && (ct_q[31:16] == 16'h0 || feed_q == 32'(ct_q[31:16])))
      else $error("closure count not cleared at trigger");
   feed_end_a: assert property (mode == M_CNTT && auto_m && tick && feed_q == 32'h1
      ##1 mode == M_CNTT && auto_m |=> !relay_out)
      else $error("feed ran past its duration");
   ds_now_a: assert property (mode == M_DUAL && ds_q == DS_OFF && on_ev
      && ond_s == 32'h0 ##1 mode == M_DUAL |-> ds_q == DS_ON)
      else $error("zero on delay not immediate");
   ds_cancel_a: assert property (mode == M_DUAL && ds_q == DS_ONDLY && off_ev
      |=> ds_q == DS_OFF || mode != M_DUAL)
      else $error("pending on delay not cancelled");

endmodule

// [hw/rly_pkg.sv]
// Package: register map, field layout, constants and types of the relay controller
package rly_pkg;

   // ****************************************
   // Register offsets (byte addresses)
   // ****************************************
   localparam logic [7:0] A_CTRL  = 8'h00;
   localparam logic [7:0] A_SEL   = 8'h04;
   localparam logic [7:0] A_ACCV  = 8'h08;
   localparam logic [7:0] A_BLDV  = 8'h0c;
   localparam logic [7:0] A_FPA   = 8'h10;
   localparam logic [7:0] A_FPB   = 8'h14;
   localparam logic [7:0] A_RATE  = 8'h18;
   localparam logic [7:0] A_CT    = 8'h1c;
   localparam logic [7:0] A_OND   = 8'h20;
   localparam logic [7:0] A_OFFD  = 8'h24;
   localparam logic [7:0] A_STAT  = 8'h28;
   localparam logic [7:0] A_IST   = 8'h2c;
   localparam logic [7:0] A_IMSK  = 8'h30;
   localparam logic [7:0] A_MKACC = 8'h34;
   localparam logic [7:0] A_REM   = 8'h38;
   localparam logic [7:0] A_CYON  = 8'h3c;
   localparam logic [7:0] A_TOTON = 8'h40;
   localparam logic [31:0] REG_RST = 32'h0000_0000;

   // ****************************************
   // Fields and codes
   // ****************************************
   localparam logic [1:0] M_RATIO = 2'h0;
   localparam logic [1:0] M_FLOWP = 2'h1;
   localparam logic [1:0] M_CNTT  = 2'h2;
   localparam logic [1:0] M_DUAL  = 2'h3;
   localparam logic [1:0] H_AUTO  = 2'h0;
   localparam logic [1:0] H_HAND  = 2'h1;
   localparam int CTRL_M3   = 2;
   localparam int EV_ON     = 0;
   localparam int EV_OFF    = 1;
   localparam int EV_LIM    = 2;
   localparam int EV_CT     = 3;
   localparam int NEV       = 4;
   localparam logic [3:0] SEL_NONE = 4'hf;

   // ****************************************
   // Arithmetic constants
   // ****************************************
   // 166.67 = 16667/100 and 0.16667 = 16667/100000; the 10000 undoes the
   // percent scaling of pump setting and hundredths of specific gravity
   localparam logic [63:0] K_DIV    = 64'h0000_0000_0000_411b;
   localparam logic [63:0] K_LG_MUL = 64'h0000_0000_000f_4240;
   localparam logic [63:0] K_M3_MUL = 64'h0000_0000_3b9a_ca00;
   localparam logic [11:0] RATE_MIN = 12'h00a;
   localparam logic [11:0] RATE_MAX = 12'h960;
   localparam logic [6:0]  PCT_FULL = 7'h64;
   localparam logic [47:0] SEC_MIN  = 48'h0000_0000_003c;
   localparam logic [31:0] HR_SEC   = 32'h0000_0e10;
   localparam logic [31:0] MIN_SEC  = 32'h0000_003c;
   localparam longint SEC_NS  = 1000000000;
   localparam longint CLK_NS  = 10;
   localparam int     SEC_CYC = int'(SEC_NS / CLK_NS);

   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic [7:0] rsv;
      logic [7:0] hh;
      logic [7:0] mm;
      logic [7:0] ss;
   } rly_hms_t;

   typedef struct packed {
      logic [1:0] rsv;
      logic       off_st;
      logic       on_st;
      logic [3:0] off_src;
      logic [3:0] on_src;
      logic [3:0] ct_src;
      logic [3:0] bl2;
      logic [3:0] bl1;
      logic [3:0] mk2;
      logic [3:0] mk1;
   } rly_sel_t;

   typedef enum logic [1:0] {DS_OFF, DS_ONDLY, DS_ON, DS_OFFDLY} rly_ds_t;

endpackage

// [test/rly_ctrl_tb.sv]
// Self-checking testbench of the relay controller
`timescale 1ns/1ps
module rly_ctrl_tb
   import rly_pkg::*;
;
   localparam int SC = 20;
   logic        clk, sys_rst, reg_wr, reg_rd, relay_out, irq, rd_p;
   logic [7:0]  reg_addr, din_pin;
   logic [31:0] reg_wdata, reg_rdata;
   logic [15:0] flow_rate;
   logic [3:0]  oth_relay, oth_auto;
   logic [63:0] exp_q[$];
   logic [63:0] mq;
   int          fail_count, checks_done, cyc, n, seed;

   rly_ctrl #(.SEC_CNT(SC)) i_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .din_pin(din_pin), .oth_relay(oth_relay), .oth_auto(oth_auto),
      .flow_rate(flow_rate), .relay_out(relay_out), .irq(irq));
   rly_far i_far (.clk(clk), .din_pin(din_pin), .oth_relay(oth_relay), .oth_auto(oth_auto));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ****************************************
   // Compare, close and bus tasks
   // ****************************************
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic end_of_test;
      $display("Checks %0d, errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge clk);
      exp_q.push_back({m, e & m});
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
   endtask
   task automatic wt(input logic v, input int mx);
      n = 0;
      while (relay_out !== v && n < mx) begin
         @(posedge clk);
         n++;
      end
   endtask
   // Counts cycles with the relay driven
   task automatic cnt(input int len);
      n = 0;
      repeat (len) begin
         @(posedge clk);
         if (relay_out === 1'b1) n++;
      end
   endtask

   // Read data stand only one cycle, so they are taken there; the ceiling cuts hangs
   always @(posedge clk) begin
      cyc  <= cyc + 1;
      rd_p <= reg_rd;
      if (rd_p) begin
         mq = exp_q.pop_front();
         cmp(reg_rdata & mq[63:32], mq[31:0]);
      end
      if (cyc == 10000) begin
         fail_count++;
         end_of_test();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      sys_rst   = 1'b1;
      reg_addr  = 8'h00;
      reg_wdata = 32'h0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      flow_rate = 16'h0000;
      rd_p      = 1'b0;
      cyc       = 0;
      seed      = 52131;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      rd(A_CTRL, '1, REG_RST);
      rd(A_IMSK, '1, REG_RST);
      wr(8'h44, $random(seed));
      rd(8'h44, '1, 32'h0);
      // Park in counter timer with setpoint 0 so the relay rests off
      wr(A_CTRL, 32'h2);
      wr(A_SEL, 32'h0000_f210);
      wr(A_ACCV, 32'h3);
      wr(A_BLDV, 32'h2);
      wr(A_IST, 32'hf);
      wr(A_IMSK, 32'h3);
      wr(A_CTRL, 32'h0);
      i_far.pulse(0, 2);
      cnt(30);
      cmp(32'(n), 32'h0);
      i_far.pulse(1, 1);
      wt(1'b1, 40);
      cmp(relay_out, 1'b1);
      rd(A_IST, 32'h3, 32'h1);
      cmp(irq, 1'b1);
      i_far.pulse(2, 1);
      i_far.pulse(3, 1);
      cnt(20);
      cmp(32'(n), 32'd20);
      i_far.pulse(2, 1);
      wt(1'b0, 40);
      cmp(relay_out, 1'b0);
      wr(A_IST, 32'h3);
      rd(A_IST, 32'hf, 32'h0);
      cmp(irq, 1'b0);
      // Third closure lands during the feed
      wr(A_IMSK, 32'h0);
      wr(A_CT, 32'h0001_0002);
      wr(A_CTRL, 32'h2);
      fork
         i_far.pulse(0, 3);
         cnt(90);
      join
      cmp(32'(n), 32'(SC));
      rd(A_MKACC, '1, 32'h1);
      rd(A_CYON, '1, 32'h1);
      rd(A_IST, 32'h8, 32'h8);
      cmp(irq, 1'b0);
      wr(A_IMSK, 32'h8);
      repeat (2) @(posedge clk);
      cmp(irq, 1'b1);
      wr(A_IST, 32'hf);
      repeat (2) @(posedge clk);
      cmp(irq, 1'b0);
      wr(A_OND, 32'h1);
      wr(A_OFFD, 32'h0);
      wr(A_SEL, 32'h3180_0000);
      wr(A_CTRL, 32'h3);
      i_far.set_oth(1'b1, 1'b0);
      cnt(50);
      cmp(32'(n), 32'h0);
      i_far.set_oth(1'b0, 1'b1);
      i_far.set_oth(1'b1, 1'b1);
      wt(1'b1, 60);
      cmp(n >= SC && n <= SC + 8, 1'b1);
      fork
         i_far.pulse(1, 1);
         wt(1'b0, 15);
      join
      cmp(n < 15 && relay_out === 1'b0, 1'b1);
      i_far.set_oth(1'b0, 1'b1);
      i_far.set_oth(1'b1, 1'b1);
      i_far.pulse(1, 1);
      cnt(40);
      cmp(32'(n), 32'h0);
      // Zero on delay: relay follows the trigger within a few cycles
      wr(A_OND, 32'h0);
      i_far.set_oth(1'b0, 1'b1);
      i_far.set_oth(1'b1, 1'b1);
      wt(1'b1, 10);
      cmp(n <= 4 && relay_out === 1'b1, 1'b1);
      i_far.pulse(1, 1);
      cmp(relay_out, 1'b0);
      wr(A_TOTON, 32'h0);
      rd(A_TOTON, '1, 32'h0);
      flow_rate <= 16'd5000;
      wr(A_FPA, 32'h0001_0001);
      wr(A_FPB, 32'h6464_6401);
      wr(A_RATE, 32'h0000_0001);
      wr(A_CTRL, 32'h1);
      repeat (200) @(posedge clk);
      rd(A_STAT, 32'h7f, 32'd29);
      flow_rate <= 16'd5;
      wr(A_CTRL, 32'h5);
      repeat (200) @(posedge clk);
      rd(A_STAT, 32'h7f, 32'd29);
      flow_rate <= 16'($random(seed));
      wr(A_CTRL, 32'h11);
      cnt(1200);
      cmp(n >= 9 && n <= 10, 1'b1);
      flow_rate <= 16'd5000;
      wr(A_RATE, 32'h0001_0960);
      wr(A_CTRL, 32'h1);
      repeat (200) @(posedge clk);
      rd(A_STAT, 32'h100, 32'h100);
      rd(A_IST, 32'h4, 32'h4);
      cnt(300);
      cmp(32'(n), 32'h0);
      end_of_test();
   end
endmodule

// [test/rly_far.sv]
// Far side model: water meters, level switches and other relays
`timescale 1ns/1ps
module rly_far (
   input  wire logic       clk,
   output logic      [7:0] din_pin,
   output logic      [3:0] oth_relay,
   output logic      [3:0] oth_auto
);
   // ****************************************
   // Contacts rest open and pulled low
   // ****************************************
   initial begin
      din_pin   = 8'h00;
      oth_relay = 4'h0;
      oth_auto  = 4'h0;
   end
   // Closures last 6 cycles so the pin filter cannot drop them
   task automatic pulse(input int idx, input int num);
      repeat (num) begin
         @(posedge clk);
         din_pin[idx] <= 1'b1;
         repeat (6) @(posedge clk);
         din_pin[idx] <= 1'b0;
         repeat (5) @(posedge clk);
      end
   endtask
   task automatic set_oth(input logic st, input logic au);
      @(posedge clk);
      oth_relay[0] <= st;
      oth_auto[0]  <= au;
   endtask
endmodule
